// [core/chroma_subcarrier_synth.sv]
// Chosen here: the APB register port.
`timescale 1ns/10ps
module chroma_subcarrier_synth (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input chroma_subcarrier_synth_pkg::timing_t timing,
    output chroma_subcarrier_synth_pkg::phase_t phase_out,
    output logic [31:0] accum_out,
    output logic sync_point
);
    import chroma_subcarrier_synth_pkg::*;

    // ==========================================
    // address decode
    function automatic logic [4:0] decode(input logic [11:0] addr);
        logic [4:0] r;
        r = 5'h00;
        if (addr[11:10] == 2'h0 && addr[1:0] == 2'h0) begin
            case (addr[9:2])
                IDX_FORMAT_MODE: r = {1'b1, S_FORMAT_MODE};
                IDX_RESET_REQ: r = {1'b1, S_RESET_REQ};
                IDX_DEC_REF: r = {1'b1, S_DEC_REF};
                IDX_LOCK_CTL: r = {1'b1, S_LOCK_CTL};
                IDX_FILT_BYP: r = {1'b1, S_FILT_BYP};
                IDX_STEP0: r = {1'b1, S_STEP0};
                IDX_STEP1: r = {1'b1, S_STEP1};
                IDX_STEP2: r = {1'b1, S_STEP2};
                IDX_STEP3: r = {1'b1, S_STEP3};
                IDX_SYS_LO: r = {1'b1, S_SYS_LO};
                IDX_SYS_HI: r = {1'b1, S_SYS_HI};
                IDX_BUR_LO: r = {1'b1, S_BUR_LO};
                IDX_BUR_HI: r = {1'b1, S_BUR_HI};
                IDX_BURST_PEAK: r = {1'b1, S_BURST_PEAK};
                IDX_RAMP_ONE: r = {1'b1, S_RAMP_ONE};
                IDX_RAMP_TWO: r = {1'b1, S_RAMP_TWO};
                default: r = 5'h00;
            endcase
        end
        return r;
    endfunction : decode

    // ==========================================
    // apb slave
    logic [4:0] dec;
    logic hit;
    logic [3:0] slot;
    logic wr_en;
    logic [7:0] regs_q [16];
    logic [31:0] prdata_q;

    assign dec = decode(paddr);
    assign hit = dec[4];
    assign slot = dec[3:0];
    assign wr_en = psel & penable & pwrite & hit & pstrb[0];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite && hit) begin
            prdata_q <= {24'h00_0000, regs_q[slot]};
        end else if (psel && !penable) begin
            prdata_q <= 32'h0000_0000;
        end
    end

    // ==========================================
    // register fields
    logic [ACC_W-1:0] step_word;
    logic [PHASE_W-1:0] system_phase_word;
    logic [PHASE_W-1:0] burst_phase_word;
    logic [1:0] format_sel;
    logic [2:0] mode_sel;
    logic reset_req;
    logic req_set;

    assign step_word = {regs_q[S_STEP3], regs_q[S_STEP2], regs_q[S_STEP1], regs_q[S_STEP0]};
    assign system_phase_word = {regs_q[S_SYS_HI], regs_q[S_SYS_LO]};
    assign burst_phase_word = {regs_q[S_BUR_HI], regs_q[S_BUR_LO]};
    assign format_sel = regs_q[S_FORMAT_MODE][FORMAT_LSB +: 2];
    assign mode_sel = regs_q[S_FORMAT_MODE][MODE_LSB +: 3];
    assign reset_req = regs_q[S_RESET_REQ][RESET_REQ_BIT];
    assign req_set = wr_en && slot == S_RESET_REQ && pwdata[RESET_REQ_BIT];

    // ==========================================
    // sync point and load decision
    logic [LINE_W-1:0] sync_line;
    logic load;

    assign sync_line = (format_sel == FORMAT_NTSC) ? NTSC_SYNC_LINE : SYNC_LINE;
    assign sync_point = timing.field_one & timing.pixel_one & (timing.line_num == sync_line);
    // free-run only realigns on request, reset mode every time
    assign load = sync_point & ((mode_sel == MODE_SC_RESET) | reset_req);

    // ==========================================
    // register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (wr_en && slot == 4'(i)) begin
                    regs_q[i] <= pwdata[7:0];
                end
            end
            // request clears itself once used, a new set wins
            if (sync_point && reset_req && !req_set) begin
                regs_q[S_RESET_REQ][RESET_REQ_BIT] <= 1'b0;
            end
        end
    end

    // ==========================================
    // phase accumulator
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;

    always_comb begin
        if (load) begin
            acc_d = {system_phase_word, 16'h0000};
        end else begin
            acc_d = acc_q + step_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign accum_out = acc_q;

    // ==========================================
    // modulator phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_out <= '0;
        end else if (timing.burst_gate) begin
            phase_out.mod_phase <= acc_q + {burst_phase_word, 16'h0000};
            phase_out.burst_sel <= 1'b1;
        end else begin
            phase_out.mod_phase <= acc_q + {system_phase_word, 16'h0000};
            phase_out.burst_sel <= 1'b0;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_acc_step;
        !load |=> acc_q == $past(acc_q) + $past(step_word);
    endproperty
    a_acc_step: assert property (p_acc_step) else $error("accumulator did not step");

    property p_acc_wrap;
        !load && (acc_q > ~step_word) |=> acc_q < $past(acc_q);
    endproperty
    a_acc_wrap: assert property (p_acc_wrap) else $error("accumulator not modulo 2^32");

    property p_sync_load;
        load |=> acc_q == {$past(system_phase_word), 16'h0000};
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("system phase not loaded");

    property p_ntsc_line;
        format_sel == FORMAT_NTSC && timing.line_num == SYNC_LINE |-> !sync_point;
    endproperty
    a_ntsc_line: assert property (p_ntsc_line) else $error("ntsc sync on wrong line");

    property p_req_clear;
        sync_point && reset_req && !req_set |=> !reset_req;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("reset request not cleared");

    property p_req_hold;
        reset_req && !sync_point && !wr_en |=> reset_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("reset request dropped early");

    property p_free_run;
        mode_sel == MODE_FREE_RUN && !reset_req |-> !load;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free-run realigned");

    property p_active_phase;
        !timing.burst_gate |=> !phase_out.burst_sel
            && phase_out.mod_phase == $past(acc_q) + {$past(system_phase_word), 16'h0000};
    endproperty
    a_active_phase: assert property (p_active_phase) else $error("active phase wrong");

    property p_burst_phase;
        timing.burst_gate |=> phase_out.burst_sel
            && phase_out.mod_phase == $past(acc_q) + {$past(burst_phase_word), 16'h0000};
    endproperty
    a_burst_phase: assert property (p_burst_phase) else $error("burst phase wrong");

    property p_step_top;
        wr_en && paddr[9:2] == IDX_STEP3 |=> step_word[31:24] == $past(pwdata[7:0]);
    endproperty
    a_step_top: assert property (p_step_top) else $error("step top byte not stored");

    property p_step_low;
        wr_en && paddr[9:2] == IDX_STEP0 |=> step_word[7:0] == $past(pwdata[7:0]);
    endproperty
    a_step_low: assert property (p_step_low) else $error("step low byte not stored");

    property p_sys_bytes;
        wr_en && paddr[9:2] == IDX_SYS_HI |=> system_phase_word[15:8] == $past(pwdata[7:0]);
    endproperty
    a_sys_bytes: assert property (p_sys_bytes) else $error("system phase byte not stored");

    property p_bur_bytes;
        wr_en && paddr[9:2] == IDX_BUR_LO |=> burst_phase_word[7:0] == $past(pwdata[7:0]);
    endproperty
    a_bur_bytes: assert property (p_bur_bytes) else $error("burst phase byte not stored");

    property p_slverr_unmapped;
        psel && penable && !hit |-> pslverr;
    endproperty
    a_slverr_unmapped: assert property (p_slverr_unmapped) else $error("unmapped access not flagged");

    property p_slverr_mapped;
        psel && penable && hit |-> !pslverr;
    endproperty
    a_slverr_mapped: assert property (p_slverr_mapped) else $error("mapped access flagged");

    property p_rd_data;
        psel && !penable && !pwrite && hit |=> prdata == {24'h00_0000, $past(regs_q[slot])};
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not captured");

    property p_rd_unmapped;
        psel && !penable && !hit |=> prdata == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_no_strobe;
        psel && penable && pwrite && hit && !pstrb[0] |=> $stable({step_word, system_phase_word, burst_phase_word});
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("write without strobe stored");

    property p_wr_unmapped;
        psel && penable && pwrite && !hit |=> $stable({step_word, system_phase_word, burst_phase_word});
    endproperty
    a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write stored");

    property p_step_byte1;
        wr_en && paddr[9:2] == IDX_STEP1 |=> step_word[15:8] == $past(pwdata[7:0]);
    endproperty
    a_step_byte1: assert property (p_step_byte1) else $error("step byte one not stored");

    property p_step_byte2;
        wr_en && paddr[9:2] == IDX_STEP2 |=> step_word[23:16] == $past(pwdata[7:0]);
    endproperty
    a_step_byte2: assert property (p_step_byte2) else $error("step byte two not stored");

    property p_sys_low;
        wr_en && paddr[9:2] == IDX_SYS_LO |=> system_phase_word[7:0] == $past(pwdata[7:0]);
    endproperty
    a_sys_low: assert property (p_sys_low) else $error("system phase low byte not stored");

    property p_bur_high;
        wr_en && paddr[9:2] == IDX_BUR_HI |=> burst_phase_word[15:8] == $past(pwdata[7:0]);
    endproperty
    a_bur_high: assert property (p_bur_high) else $error("burst phase high byte not stored");

    property p_req_set_wins;
        req_set |=> reset_req;
    endproperty
    a_req_set_wins: assert property (p_req_set_wins) else $error("reset request set lost");

    property p_sc_reset;
        mode_sel == MODE_SC_RESET && sync_point |-> load;
    endproperty
    a_sc_reset: assert property (p_sc_reset) else $error("reset mode did not realign");

    property p_pal_line;
        format_sel != FORMAT_NTSC && timing.field_one && timing.pixel_one
            && timing.line_num == SYNC_LINE |-> sync_point;
    endproperty
    a_pal_line: assert property (p_pal_line) else $error("line one sync missed");

    property p_sync_field;
        !timing.field_one |-> !sync_point;
    endproperty
    a_sync_field: assert property (p_sync_field) else $error("sync outside field one");

endmodule : chroma_subcarrier_synth

// [core/chroma_subcarrier_synth_pkg.sv]
package chroma_subcarrier_synth_pkg;
    // ==========================================
    // widths
    localparam int ACC_W = 32;
    localparam int PHASE_W = 16;
    localparam int LINE_W = 10;
    // ==========================================
    // register indices, byte address is index times four
    localparam logic [7:0] IDX_FORMAT_MODE = 8'h06;
    localparam logic [7:0] IDX_RESET_REQ = 8'h07;
    localparam logic [7:0] IDX_DEC_REF = 8'h11;
    localparam logic [7:0] IDX_LOCK_CTL = 8'h18;
    localparam logic [7:0] IDX_FILT_BYP = 8'h3f;
    localparam logic [7:0] IDX_STEP0 = 8'h40;
    localparam logic [7:0] IDX_STEP1 = 8'h41;
    localparam logic [7:0] IDX_STEP2 = 8'h42;
    localparam logic [7:0] IDX_STEP3 = 8'h43;
    localparam logic [7:0] IDX_SYS_LO = 8'h44;
    localparam logic [7:0] IDX_SYS_HI = 8'h45;
    localparam logic [7:0] IDX_BUR_LO = 8'h46;
    localparam logic [7:0] IDX_BUR_HI = 8'h47;
    localparam logic [7:0] IDX_BURST_PEAK = 8'h48;
    localparam logic [7:0] IDX_RAMP_ONE = 8'h49;
    localparam logic [7:0] IDX_RAMP_TWO = 8'h4a;
    // ==========================================
    // storage slots
    localparam logic [3:0] S_FORMAT_MODE = 4'h0;
    localparam logic [3:0] S_RESET_REQ = 4'h1;
    localparam logic [3:0] S_DEC_REF = 4'h2;
    localparam logic [3:0] S_LOCK_CTL = 4'h3;
    localparam logic [3:0] S_FILT_BYP = 4'h4;
    localparam logic [3:0] S_STEP0 = 4'h5;
    localparam logic [3:0] S_STEP1 = 4'h6;
    localparam logic [3:0] S_STEP2 = 4'h7;
    localparam logic [3:0] S_STEP3 = 4'h8;
    localparam logic [3:0] S_SYS_LO = 4'h9;
    localparam logic [3:0] S_SYS_HI = 4'ha;
    localparam logic [3:0] S_BUR_LO = 4'hb;
    localparam logic [3:0] S_BUR_HI = 4'hc;
    localparam logic [3:0] S_BURST_PEAK = 4'hd;
    localparam logic [3:0] S_RAMP_ONE = 4'he;
    localparam logic [3:0] S_RAMP_TWO = 4'hf;
    // ==========================================
    // fields, codes, reset values
    localparam int FORMAT_LSB = 6;
    localparam int MODE_LSB = 3;
    localparam int RESET_REQ_BIT = 5;
    localparam logic [1:0] FORMAT_NTSC = 2'h0;
    localparam logic [2:0] MODE_FREE_RUN = 3'h0;
    localparam logic [2:0] MODE_SC_RESET = 3'h1;
    localparam logic [LINE_W-1:0] SYNC_LINE = 10'h001;
    localparam logic [LINE_W-1:0] NTSC_SYNC_LINE = 10'h004;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
    // ==========================================
    // carriers
    typedef struct packed {
        logic field_one;
        logic [LINE_W-1:0] line_num;
        logic pixel_one;
        logic burst_gate;
    } timing_t;
    typedef struct packed {
        logic [ACC_W-1:0] mod_phase;
        logic burst_sel;
    } phase_t;
endpackage : chroma_subcarrier_synth_pkg

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
    import chroma_subcarrier_synth_pkg::*;
    // ==========================================
    // signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, accum_out, rd, a, b, stp;
    logic pready, pslverr, sync_point, err, sp;
    timing_t timing = '0;
    phase_t phase_out;
    int error_cnt = 0, total_checks = 0, seed = 2;
    logic [7:0] mreg [0:255];
    logic [7:0] v;
    logic [15:0] sys, bur;
    longint num;
    // test pixel rate and line periods in ns, pixels per line = rate times period
    localparam int PIX_KHZ = 13500;
    localparam int NTSC_PIX = PIX_KHZ * 63556 / 1000000;
    localparam int PAL_PIX = PIX_KHZ * 64000 / 1000000;
    localparam int PALM_PIX = PIX_KHZ * 63492 / 1000000;
    logic [7:0] idx_list [16] = '{IDX_FORMAT_MODE, IDX_RESET_REQ, IDX_DEC_REF, IDX_LOCK_CTL, IDX_FILT_BYP,
        IDX_STEP0, IDX_STEP1, IDX_STEP2, IDX_STEP3, IDX_SYS_LO, IDX_SYS_HI, IDX_BUR_LO, IDX_BUR_HI,
        IDX_BURST_PEAK, IDX_RAMP_ONE, IDX_RAMP_TWO};

    always #25 pclk = ~pclk;

    chroma_subcarrier_synth dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timing(timing), .phase_out(phase_out), .accum_out(accum_out),
        .sync_point(sync_point));

    // ==========================================
    // tasks
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {d, d, d, d};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) error_cnt++;
    endtask : apb

    task wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 4'h1);
        mreg[idx] = d;
    endtask : wr

    task rchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, 4'h0);
        chk32(rd, {24'h0, exp});
    endtask : rchk

    task set_step(input logic [31:0] s);
        wr(IDX_STEP0, s[7:0]);
        wr(IDX_STEP1, s[15:8]);
        wr(IDX_STEP2, s[23:16]);
        wr(IDX_STEP3, s[31:24]);
    endtask : set_step

    // free-run for n pixels, accumulator must advance by n steps
    task run_chk(input int n, input logic [31:0] s);
        @(posedge pclk);
        #1 a = accum_out;
        repeat (n) @(posedge pclk);
        #1 chk32(accum_out, a + n * s);
    endtask : run_chk

    // a: accumulator before the sync edge, b: after it
    task pulse(input logic [9:0] ln);
        @(posedge pclk);
        timing <= {1'b1, ln, 1'b1, 1'b0};
        #1 a = accum_out;
        sp = sync_point;
        @(posedge pclk);
        timing.pixel_one <= 1'b0;
        #1 b = accum_out;
    endtask : pulse

    task complete_run;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // ==========================================
    // sequence
    initial begin
        for (int i = 0; i < 256; i++) mreg[i] = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (idx_list[i]) rchk(idx_list[i], 8'h00);
        foreach (idx_list[i]) begin
            v = $random(seed);
            if (idx_list[i] != IDX_FORMAT_MODE && idx_list[i] != IDX_RESET_REQ) wr(idx_list[i], v);
        end
        foreach (idx_list[i]) rchk(idx_list[i], mreg[idx_list[i]]);
        apb(1'b1, IDX_STEP0, ~mreg[IDX_STEP0], 4'h0);
        rchk(IDX_STEP0, mreg[IDX_STEP0]);
        apb(1'b1, 8'h50, 8'hff, 4'h1);
        chk32({31'h0, err}, 32'h1);
        apb(1'b0, 8'h50, 8'h00, 4'h0);
        chk32({31'h0, err}, 32'h1);
        chk32(rd, 32'h0);
        stp = {mreg[IDX_STEP3], mreg[IDX_STEP2], mreg[IDX_STEP1], mreg[IDX_STEP0]};
        @(posedge pclk);
        #1 a = accum_out;
        repeat (5) @(posedge pclk);
        #1 chk32(accum_out, a + 5 * stp);
        pulse(NTSC_SYNC_LINE);
        chk32({31'h0, sp}, 32'h1);
        chk32(b, a + stp);
        sys = {mreg[IDX_SYS_HI], mreg[IDX_SYS_LO]};
        wr(IDX_RESET_REQ, 8'h20);
        rchk(IDX_RESET_REQ, 8'h20);
        pulse(NTSC_SYNC_LINE);
        chk32(b, {sys, 16'h0});
        rchk(IDX_RESET_REQ, 8'h00);
        for (int f = 0; f < 2; f++) begin
            wr(IDX_FORMAT_MODE, f ? 8'h48 : 8'h08);
            v = $random(seed);
            wr(IDX_SYS_HI, v);
            sys = {mreg[IDX_SYS_HI], mreg[IDX_SYS_LO]};
            pulse(f ? SYNC_LINE : NTSC_SYNC_LINE);
            chk32(b, {sys, 16'h0});
            pulse(f ? NTSC_SYNC_LINE : SYNC_LINE);
            chk32(b, a + stp);
        end
        wr(IDX_FORMAT_MODE, 8'h00);
        bur = {mreg[IDX_BUR_HI], mreg[IDX_BUR_LO]};
        for (int g = 0; g < 2; g++) begin
            @(posedge pclk);
            timing.burst_gate <= g[0];
            #1 a = accum_out;
            @(posedge pclk);
            #1 chk32(phase_out.mod_phase, a + (g ? {bur, 16'h0} : {sys, 16'h0}));
            chk32({31'h0, phase_out.burst_sel}, g);
        end
        // step words worked out from the line formulas
        num = (64'd455 << 32) / (64'd2 * NTSC_PIX);
        stp = num[31:0];
        set_step(stp);
        run_chk(2 * NTSC_PIX, stp);
        num = ((64'd1135 * 64'd625 + 64'd4) << 32) / (64'd2500 * PAL_PIX);
        stp = num[31:0];
        set_step(stp);
        run_chk(64, stp);
        num = (64'd909 << 32) / (64'd4 * PALM_PIX);
        stp = num[31:0];
        set_step(stp);
        run_chk(64, stp);
        // nominal zero system phase, then a random system phase with burst phase equal to it
        wr(IDX_SYS_LO, 8'h00);
        wr(IDX_SYS_HI, 8'h00);
        wr(IDX_RESET_REQ, 8'h20);
        pulse(NTSC_SYNC_LINE);
        chk32(b, 32'h0);
        v = $random(seed);
        sys = {v, ~v};
        wr(IDX_SYS_LO, sys[7:0]);
        wr(IDX_SYS_HI, sys[15:8]);
        wr(IDX_BUR_LO, sys[7:0]);
        wr(IDX_BUR_HI, sys[15:8]);
        @(posedge pclk);
        timing.burst_gate <= 1'b1;
        #1 a = accum_out;
        @(posedge pclk);
        #1 chk32(phase_out.mod_phase, a + {sys, 16'h0});
        complete_run;
    end

    initial begin
        #(10000 * 50);
        error_cnt++;
        complete_run;
    end
endmodule : tb
